// ===== src/dhsm_cfg.svh
// Behaviour
// - Arithmetic shift moves both 16-bit halves together, same distance, nothing crosses.
// - Arithmetic right shift fills vacated upper bits with the half's sign.
// - Arithmetic left shift without saturation acts as a logical left shift.
// - Saturating left shift clamps to max positive or negative, keeping sign.
// - Immediate arithmetic right shift takes an unsigned distance 0 to 15.
// - Register shift: positive goes left (saturating if asked), negative goes right.
// - Register magnitude valid -16 to +15; higher bits are ignored.
// - Shifts set zero flag if a half is zero, negative if one is negative.
// - Arithmetic shift sets overflow if either half overflows, else clears it.
// - Sticky overflow sets with overflow, otherwise holds.
// - All other status bits stay unchanged.
// - Logical shift works per half, drops shifted-out bits, fills with zeros.
// - Register logical shift: positive magnitude left, negative right.
// - Immediate logical shifts take an unsigned 4-bit distance 0 to 15.
// - Maximum compares upper and lower halves apart, larger goes to each half.
// - Maximum compares the halves as signed numbers.
// - Maximum sets zero and negative flags per halves and clears overflow.
// - Sources stay unchanged unless the destination is the same register.
`ifndef DHSM_CFG_SVH
`define DHSM_CFG_SVH

// ----------------------------------------
// Register map, byte addresses
// ----------------------------------------
`define DHSM_DATA_BASE   6'h00
`define DHSM_DATA_LAST   6'h1c
`define DHSM_CMD_ADDR    6'h20
`define DHSM_STAT_ADDR   6'h24

// ----------------------------------------
// Status word bits and reset values
// ----------------------------------------
`define DHSM_ZERO_BIT    0
`define DHSM_NEG_BIT     1
`define DHSM_OVF_BIT     24
`define DHSM_STICKY_BIT  25
`define DHSM_STAT_RST    32'h0000_0000
`define DHSM_DATA_RST    32'h0000_0000

`endif

// ===== src/dhsm_pkg.sv
package dhsm_pkg;

	typedef logic [31:0] dhsm_word_t;

	typedef enum logic [2:0] {
		DHSM_ASR_IMM = 3'b000,
		DHSM_ASL_IMM = 3'b001,
		DHSM_ASH_REG = 3'b010,
		DHSM_LSR_IMM = 3'b011,
		DHSM_LSL_IMM = 3'b100,
		DHSM_LSH_REG = 3'b101,
		DHSM_MAX     = 3'b110,
		DHSM_NOP     = 3'b111
	} dhsm_op_t;

	// Command word layout, high bits first
	typedef struct packed {
		logic [12:0] unused;
		logic [2:0]  src1;
		logic        pad2;
		logic [2:0]  src0;
		logic        pad1;
		logic [2:0]  dst;
		logic [3:0]  imm;
		logic        sat;
		dhsm_op_t    op;
	} dhsm_cmd_t;

	typedef struct packed {
		logic        ovf;
		logic [15:0] val;
	} dhsm_half_t;

endpackage

// ===== src/dhsm_unit.sv
`timescale 1ns/1ps
`include "dhsm_cfg.svh"

module dhsm_unit (
	input  wire logic               clk_sys_in,
	input  wire logic               nrst_in,
	input  wire logic [5:0]         avs_address_in,
	input  wire logic               avs_read_in,
	input  wire logic               avs_write_in,
	input  wire dhsm_pkg::dhsm_word_t avs_writedata_in,
	input  wire logic [3:0]         avs_byteenable_in,
	output dhsm_pkg::dhsm_word_t    avs_readdata_out,
	output logic                    avs_waitrequest_out,
	output dhsm_pkg::dhsm_word_t    arith_status_word_out
);
	import dhsm_pkg::*;

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	logic       wait_q;
	dhsm_word_t rdata_q;
	dhsm_word_t rf_q [8];
	dhsm_word_t stat_q;
	logic       req;
	logic       take;
	logic       is_data;
	logic [2:0] widx;
	dhsm_word_t wmask;

	assign req     = avs_read_in | avs_write_in;
	// Write lands only on the edge where waitrequest is seen low
	assign take    = avs_write_in & ~wait_q;
	assign is_data = avs_address_in <= `DHSM_DATA_LAST;
	assign widx    = avs_address_in[4:2];

	// One wait cycle per access; idle holds waitrequest high
	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
			wait_q <= 1'b1;
		else
			wait_q <= ~(req & wait_q);
	end

	always_comb
	begin
		wmask = '0;
		for (int i = 0; i < 4; i++)
			wmask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
			rdata_q <= '0;
		else if (avs_read_in & wait_q)
		begin
			if (is_data)
				rdata_q <= rf_q[widx];
			else if (avs_address_in[5:2] == 4'(`DHSM_CMD_ADDR >> 2))
				rdata_q <= '0;
			else if (avs_address_in[5:2] == 4'(`DHSM_STAT_ADDR >> 2))
				rdata_q <= stat_q;
			else
				rdata_q <= '0;
		end
	end

	// ----------------------------------------
	// Shift core for one half
	// ----------------------------------------
	function automatic dhsm_half_t shift_half(
		input logic [15:0] x,
		input logic [4:0]  cnt,
		input logic        arith,
		input logic        sat
	);
		logic [4:0]         n;
		logic [31:0]        w;
		logic [31:0]        wl;
		logic signed [31:0] wr;
		dhsm_half_t         h;
		n  = cnt[4] ? 5'(~cnt + 5'h01) : cnt;
		w  = {{16{x[15]}}, x};
		wl = w << n;
		wr = $signed(w) >>> n;
		h.ovf = 1'b0;
		if (cnt[4])
		begin
			// Arithmetic keeps sign; logical fills zeros
			h.val = arith ? wr[15:0] : x >> n;
		end
		else
		begin
			// Sign bits may fall off the top unless saturating
			h.val = wl[15:0];
			h.ovf = arith & ~((&wl[31:15]) | ~(|wl[31:15]));
			if (arith & sat & h.ovf)
				h.val = x[15] ? 16'h8000 : 16'h7fff;
		end
		return h;
	endfunction

	// ----------------------------------------
	// Command decode and execute
	// ----------------------------------------
	dhsm_cmd_t  cmd;
	dhsm_word_t a;
	dhsm_word_t b;
	logic       exec;
	logic [4:0] cnt;
	logic       arith;
	logic       is_max;
	dhsm_half_t hh;
	dhsm_half_t hl;
	dhsm_word_t res;
	dhsm_word_t stat_d;

	assign cmd  = dhsm_cmd_t'(avs_writedata_in);
	assign a    = rf_q[cmd.src0];
	assign b    = rf_q[cmd.src1];
	assign exec = take & (avs_address_in == `DHSM_CMD_ADDR) & (cmd.op != DHSM_NOP);

	always_comb
	begin
		arith  = 1'b0;
		is_max = 1'b0;
		cnt    = 5'h00;
		case (cmd.op)
			DHSM_ASR_IMM:
			begin
				arith = 1'b1;
				cnt   = 5'(~{1'b0, cmd.imm} + 5'h01);
			end
			DHSM_ASL_IMM:
			begin
				arith = 1'b1;
				cnt   = {1'b0, cmd.imm};
			end
			DHSM_ASH_REG:
			begin
				arith = 1'b1;
				cnt   = b[4:0];
			end
			DHSM_LSR_IMM:
				cnt = 5'(~{1'b0, cmd.imm} + 5'h01);
			DHSM_LSL_IMM:
				cnt = {1'b0, cmd.imm};
			DHSM_LSH_REG:
				cnt = b[4:0];
			DHSM_MAX:
				is_max = 1'b1;
			default:
				cnt = 5'h00;
		endcase
	end

	// Same count to both halves, no carry between them
	assign hh = shift_half(a[31:16], cnt, arith, cmd.sat);
	assign hl = shift_half(a[15:0], cnt, arith, cmd.sat);

	always_comb
	begin
		if (is_max)
		begin
			res[31:16] = ($signed(a[31:16]) >= $signed(b[31:16])) ? a[31:16] : b[31:16];
			res[15:0]  = ($signed(a[15:0]) >= $signed(b[15:0])) ? a[15:0] : b[15:0];
		end
		else
			res = {hh.val, hl.val};
	end

	always_comb
	begin
		// Only four bits move; the rest is carried over as is
		stat_d = stat_q;
		stat_d[`DHSM_ZERO_BIT] = (res[31:16] == 16'h0000) | (res[15:0] == 16'h0000);
		stat_d[`DHSM_NEG_BIT]  = res[31] | res[15];
		// Overflow only from the arithmetic path; logical and max clear it
		stat_d[`DHSM_OVF_BIT]  = arith & (hh.ovf | hl.ovf);
		if (arith & (hh.ovf | hl.ovf))
			stat_d[`DHSM_STICKY_BIT] = 1'b1;
	end

	// ----------------------------------------
	// Data registers and status word
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_rf
			always_ff @(posedge clk_sys_in or negedge nrst_in)
			begin
				if (!nrst_in)
					rf_q[gi] <= `DHSM_DATA_RST;
				else if (exec && cmd.dst == 3'(gi))
					rf_q[gi] <= res;
				else if (take && is_data && widx == 3'(gi))
					rf_q[gi] <= (rf_q[gi] & ~wmask) | (avs_writedata_in & wmask);
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
			stat_q <= `DHSM_STAT_RST;
		else if (exec)
			stat_q <= stat_d;
		else if (take && avs_address_in == `DHSM_STAT_ADDR)
			stat_q <= (stat_q & ~wmask) | (avs_writedata_in & wmask);
	end

	assign avs_readdata_out      = rdata_q;
	assign avs_waitrequest_out   = wait_q;
	assign arith_status_word_out = stat_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic       done_q;
	dhsm_op_t   op_q;
	logic       sat_q;
	logic [2:0] dst_q;
	logic [2:0] s0_q;
	dhsm_word_t a_q;
	dhsm_word_t b_q;
	dhsm_word_t st_q;
	dhsm_word_t r;
	dhsm_word_t omask;

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			done_q <= 1'b0;
			op_q   <= DHSM_NOP;
			sat_q  <= 1'b0;
			dst_q  <= 3'h0;
			s0_q   <= 3'h0;
			a_q    <= '0;
			b_q    <= '0;
			st_q   <= '0;
		end
		else
		begin
			done_q <= exec;
			op_q   <= cmd.op;
			sat_q  <= cmd.sat;
			dst_q  <= cmd.dst;
			s0_q   <= cmd.src0;
			a_q    <= a;
			b_q    <= b;
			st_q   <= stat_q;
		end
	end

	assign r     = rf_q[dst_q];
	assign omask = ~((32'h1 << `DHSM_ZERO_BIT) | (32'h1 << `DHSM_NEG_BIT)
		| (32'h1 << `DHSM_OVF_BIT) | (32'h1 << `DHSM_STICKY_BIT));

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);

	sequence s_ack;
		!avs_waitrequest_out;
	endsequence
	sequence s_rearm;
		avs_waitrequest_out;
	endsequence

	property p_bus;
		(req && wait_q) |=> s_ack ##1 s_rearm;
	endproperty
	a_bus: assert property (p_bus) else $error("waitrequest not one cycle");

	property p_max;
		done_q && op_q == DHSM_MAX |->
			$signed(r[31:16]) >= $signed(a_q[31:16]) && $signed(r[31:16]) >= $signed(b_q[31:16])
			&& $signed(r[15:0]) >= $signed(a_q[15:0]) && $signed(r[15:0]) >= $signed(b_q[15:0])
			&& (r[31:16] == a_q[31:16] || r[31:16] == b_q[31:16])
			&& (r[15:0] == a_q[15:0] || r[15:0] == b_q[15:0]);
	endproperty
	a_max: assert property (p_max) else $error("max result wrong");

	property p_zero;
		done_q |-> stat_q[`DHSM_ZERO_BIT] == (r[31:16] == 16'h0000 || r[15:0] == 16'h0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_neg;
		done_q |-> stat_q[`DHSM_NEG_BIT] == (r[31] || r[15]);
	endproperty
	a_neg: assert property (p_neg) else $error("negative flag wrong");

	property p_vclr;
		done_q && op_q inside {DHSM_LSR_IMM, DHSM_LSL_IMM, DHSM_LSH_REG, DHSM_MAX}
			|-> !stat_q[`DHSM_OVF_BIT] && stat_q[`DHSM_STICKY_BIT] == st_q[`DHSM_STICKY_BIT];
	endproperty
	a_vclr: assert property (p_vclr) else $error("overflow not cleared");

	property p_sticky;
		done_q |-> stat_q[`DHSM_STICKY_BIT] == (st_q[`DHSM_STICKY_BIT] | stat_q[`DHSM_OVF_BIT]);
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky flag wrong");

	property p_other;
		done_q |-> (stat_q & omask) == (st_q & omask);
	endproperty
	a_other: assert property (p_other) else $error("other status changed");

	property p_sign;
		done_q && sat_q && op_q inside {DHSM_ASR_IMM, DHSM_ASL_IMM, DHSM_ASH_REG}
			|-> r[31] == a_q[31] && r[15] == a_q[15];
	endproperty
	a_sign: assert property (p_sign) else $error("sign not kept");

	property p_src;
		done_q && dst_q != s0_q |-> rf_q[s0_q] == a_q;
	endproperty
	a_src: assert property (p_src) else $error("source register altered");

	property p_asr;
		done_q && op_q == DHSM_ASR_IMM |-> r[31] == a_q[31] && r[15] == a_q[15]
			&& !stat_q[`DHSM_OVF_BIT];
	endproperty
	a_asr: assert property (p_asr) else $error("right shift lost sign");

	// Zero fill can never make an unsigned half larger
	property p_lsr;
		done_q && op_q == DHSM_LSR_IMM |-> r[31:16] <= a_q[31:16] && r[15:0] <= a_q[15:0];
	endproperty
	a_lsr: assert property (p_lsr) else $error("logical right shift grew");

	property p_sat;
		done_q && sat_q && stat_q[`DHSM_OVF_BIT] && op_q inside {DHSM_ASL_IMM, DHSM_ASH_REG}
			|-> r[31:16] inside {16'h7fff, 16'h8000} || r[15:0] inside {16'h7fff, 16'h8000};
	endproperty
	a_sat: assert property (p_sat) else $error("saturated value missing");

	property p_ovfar;
		done_q && stat_q[`DHSM_OVF_BIT] |-> op_q inside {DHSM_ASL_IMM, DHSM_ASH_REG};
	endproperty
	a_ovfar: assert property (p_ovfar) else $error("overflow outside left shift");

	// Read data must not move in the cycle after it was handed over
	property p_rdhold;
		!avs_waitrequest_out |=> $stable(avs_readdata_out);
	endproperty
	a_rdhold: assert property (p_rdhold) else $error("read data moved after answer");

endmodule

// ===== sim/dhsm_host.sv
`timescale 1ns/1ps

module dhsm_host (
	input  wire logic                 clk_sys_in,
	output logic [5:0]                avs_address_out,
	output logic                      avs_read_out,
	output logic                      avs_write_out,
	output dhsm_pkg::dhsm_word_t      avs_writedata_out,
	output logic [3:0]                avs_byteenable_out,
	input  wire dhsm_pkg::dhsm_word_t avs_readdata_in,
	input  wire logic                 avs_waitrequest_in
);
	import dhsm_pkg::*;

	initial
	begin
		avs_address_out = 6'h00;
		avs_read_out = 1'b0;
		avs_write_out = 1'b0;
		avs_writedata_out = 32'h0000_0000;
		avs_byteenable_out = 4'hf;
	end

	// --------------------------------
	// One bus cycle, held until answered
	// --------------------------------
	task automatic access(input logic [5:0] a, input logic rw, input dhsm_word_t d,
		input logic [3:0] b, output dhsm_word_t q);
		@(posedge clk_sys_in);
		avs_address_out <= a;
		avs_read_out <= !rw;
		avs_write_out <= rw;
		avs_writedata_out <= d;
		avs_byteenable_out <= b;
		do @(posedge clk_sys_in); while (avs_waitrequest_in !== 1'b0);
		q = avs_readdata_in;
		avs_read_out <= 1'b0;
		avs_write_out <= 1'b0;
		// Released lines move so stale values never look valid
		avs_writedata_out <= ~d;
		avs_address_out <= ~a;
	endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps

module tb;
	import dhsm_pkg::*;

	logic       clk_sys_in;
	logic       nrst_in;
	logic [5:0] addr;
	logic       rd_en;
	logic       wr_en;
	logic [3:0] be;
	logic       wait_rq;
	dhsm_word_t wdata;
	dhsm_word_t rdata;
	dhsm_word_t stat;
	dhsm_word_t exp_stat;
	dhsm_word_t q;
	int         error_cnt;
	int         comparisons;
	int         test_no;

	dhsm_unit dhsm_unit_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
		.avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
		.avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wait_rq), .arith_status_word_out(stat));

	dhsm_host dhsm_host_inst (.clk_sys_in(clk_sys_in), .avs_address_out(addr),
		.avs_read_out(rd_en), .avs_write_out(wr_en), .avs_writedata_out(wdata),
		.avs_byteenable_out(be), .avs_readdata_in(rdata), .avs_waitrequest_in(wait_rq));

	initial
	begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input dhsm_word_t seen, input dhsm_word_t exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input dhsm_word_t d);
		dhsm_host_inst.access(a, 1'b1, d, 4'hf, q);
	endtask

	task automatic rd(input logic [5:0] a);
		dhsm_host_inst.access(a, 1'b0, 32'h0000_0000, 4'hf, q);
	endtask

	// --------------------------------
	// Reference behaviour per half
	// --------------------------------
	function automatic logic [16:0] sh(input logic [2:0] op, input logic s,
		input logic [3:0] imm, input logic [15:0] x, input logic [4:0] c);
		logic signed [5:0] n;
		logic [5:0]        k;
		logic [31:0]       w;
		logic              ar;
		logic              ov;
		ar = op <= 3'd2;
		n = (op == 3'd2 || op == 3'd5) ? {c[4], c} :
			(op == 3'd0 || op == 3'd3) ? -{2'b00, imm} : {2'b00, imm};
		k = -n;
		if (n < 0)
		begin
			if (ar)
				w = $signed({{16{x[15]}}, x}) >>> k;
			else
				w = {16'h0000, x} >> k;
			return {1'b0, w[15:0]};
		end
		w = {{16{x[15]}}, x} << n;
		ov = ar && !((&w[31:15]) || !(|w[31:15]));
		return {ov, (ov && s) ? (x[15] ? 16'h8000 : 16'h7fff) : w[15:0]};
	endfunction

	function automatic logic [16:0] mx(input logic [15:0] x, input logic [15:0] y);
		return {1'b0, ($signed(x) > $signed(y)) ? x : y};
	endfunction

	task automatic run(input logic [2:0] op, input logic s, input logic [3:0] imm,
		input logic [2:0] dst, input dhsm_word_t a, input dhsm_word_t b);
		dhsm_cmd_t   c;
		logic [16:0] hi;
		logic [16:0] lo;
		dhsm_word_t  r;
		c = '0;
		c.op = dhsm_op_t'(op);
		c.sat = s;
		c.imm = imm;
		c.dst = dst;
		c.src1 = 3'h1;
		wr(6'h00, a);
		wr(6'h04, b);
		wr(6'h20, c);
		hi = (op == 3'd6) ? mx(a[31:16], b[31:16]) : sh(op, s, imm, a[31:16], b[4:0]);
		lo = (op == 3'd6) ? mx(a[15:0], b[15:0]) : sh(op, s, imm, a[15:0], b[4:0]);
		r = {hi[15:0], lo[15:0]};
		exp_stat[0] = (hi[15:0] == 16'h0000) || (lo[15:0] == 16'h0000);
		exp_stat[1] = hi[15] | lo[15];
		exp_stat[24] = hi[16] | lo[16];
		exp_stat[25] = exp_stat[25] | hi[16] | lo[16];
		rd({1'b0, dst, 2'b00});
		chk(q, r);
		rd(6'h24);
		chk(q, exp_stat);
		chk(stat, exp_stat);
		if (dst != 3'h0)
		begin
			rd(6'h00);
			chk(q, a);
		end
		test_no++;
		$display("test %0d done", test_no);
	endtask

	// Bounded by a generous multiple of the expected run length
	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		error_cnt++;
		test_done();
	end

	initial
	begin
		nrst_in = 1'b0;
		error_cnt = 0;
		comparisons = 0;
		test_no = 0;
		repeat (20) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		chk(stat, 32'h0000_0000);
		rd(6'h0c);
		chk(q, 32'h0000_0000);
		wr(6'h30, 32'h5a5a_5a5a);
		rd(6'h30);
		chk(q, 32'h0000_0000);
		rd(6'h20);
		chk(q, 32'h0000_0000);
		dhsm_host_inst.access(6'h24, 1'b1, 32'hffff_ffff, 4'b0100, q);
		dhsm_host_inst.access(6'h24, 1'b1, 32'h3c00_00f0, 4'b1001, q);
		exp_stat = 32'h3cff_00f0;
		rd(6'h24);
		chk(q, exp_stat);
		test_no++;
		$display("test %0d done", test_no);
		run(3'd0, 1'b0, 4'd3, 3'd2, 32'h8004_000f, 32'h0000_0000);
		rd(6'h08);
		chk(q, 32'hf000_0001);
		run(3'd0, 1'b1, 4'd15, 3'd2, 32'h8000_7fff, 32'h0000_0000);
		run(3'd1, 1'b0, 4'd4, 3'd2, 32'h4001_0003, 32'h0000_0000);
		run(3'd1, 1'b1, 4'd4, 3'd3, 32'h4001_c000, 32'h0000_0000);
		run(3'd4, 1'b0, 4'd15, 3'd3, 32'h0001_ffff, 32'h0000_0000);
		run(3'd3, 1'b0, 4'd15, 3'd3, 32'h8000_ffff, 32'h0000_0000);
		rd(6'h0c);
		chk(q, 32'h0001_0001);
		run(3'd2, 1'b0, 4'd0, 3'd4, 32'h1234_8765, 32'hffff_fff0);
		run(3'd2, 1'b1, 4'd0, 3'd4, 32'h0100_ff00, 32'h0000_0027);
		run(3'd2, 1'b0, 4'd0, 3'd4, 32'h4000_0001, 32'h0000_0001);
		run(3'd5, 1'b0, 4'd0, 3'd5, 32'h00f0_8001, 32'h0000_001c);
		run(3'd5, 1'b1, 4'd0, 3'd5, 32'h00f0_8001, 32'hff00_0004);
		run(3'd5, 1'b0, 4'd0, 3'd5, 32'h00f0_8001, 32'h0000_0010);
		run(3'd6, 1'b0, 4'd0, 3'd6, 32'hfff7_8000, 32'h000a_7fff);
		rd(6'h18);
		chk(q, 32'h000a_7fff);
		run(3'd6, 1'b0, 4'd0, 3'd0, 32'h0007_0000, 32'h0000_000f);
		rd(6'h00);
		chk(q, 32'h0007_000f);
		run(3'd6, 1'b0, 4'd0, 3'd6, 32'h1234_5678, 32'h0000_000f);
		rd(6'h18);
		chk(q, 32'h1234_5678);
		// Op code 7 leaves registers and status alone
		wr(6'h20, 32'h0000_0307);
		rd(6'h0c);
		chk(q, 32'h0001_0001);
		rd(6'h24);
		chk(q, exp_stat);
		// Reset in mid-run, bus idle, clears status and data
		@(posedge clk_sys_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		chk(stat, 32'h0000_0000);
		rd(6'h18);
		chk(q, 32'h0000_0000);
		test_no++;
		$display("test %0d done", test_no);
		test_done();
	end
endmodule
